/* net_card_supervisor_cfg.svh */
// Constants of the network card supervisor: command codes, type codes, field values and timing
`ifndef NET_CARD_SUPERVISOR_CFG_SVH
`define NET_CARD_SUPERVISOR_CFG_SVH

// ==========================================================================
// Timing and payload limit
`define CLK_MHZ            25
`define WDT_UNIT_US        25000
`define RESUME_US          25000
`define HWWDT_UNITS        40
`define MAX_PAYLOAD        5'hF

// ==========================================================================
// Command register numbers
`define CMD_RESET          8'h01
`define CMD_SET_TMO        8'h02
`define CMD_WDT_EN         8'h03
`define CMD_HIT            8'h04
`define CMD_RD_RST         8'h05
`define CMD_RD_COMM        8'h06

// ==========================================================================
// Type codes
`define RST_HARD           8'h00
`define RST_SOFT           8'h01
`define WDT_BOTH           8'h00
`define WDT_HW_ONLY        8'h01
`define WDT_SW_ONLY        8'h02

// ==========================================================================
// Field values
`define STATE_READY        2'h1
`define STATE_BUSY         2'h2
`define BYTE_ZERO          8'h00

`endif

/* net_card_supervisor_pkg.sv */
// Types shared by the network card supervisor
package net_card_supervisor_pkg;

    typedef enum logic [2:0] {
        ST_RUN  = 3'h1,
        ST_HARD = 3'h2,
        ST_SOFT = 3'h4
    } rst_state_e;

    typedef struct packed {
        logic [1:0] state;
        logic       router;
        logic       comm_err;
        logic [1:0] card;
        logic       unexec;
        logic       wdt_exp;
    } txn_status_s;

    typedef struct packed {
        logic       hard_occ;
        logic       soft_occ;
        logic       hw_en;
        logic       sw_en;
        logic [3:0] rsvd;
    } rst_status_s;

    typedef struct packed {
        logic       rx_wait;
        logic       collision;
        logic       overrun;
        logic       mode_fault;
        logic       compare;
        logic [2:0] rsvd;
    } comm_status_s;

endpackage

/* net_card_supervisor.sv */
// Supervisor of a serial network card: link framing, watchdogs, reset sequencing
//
// Overview of operation
// - Zero payload means command number only
// - First reply byte is previous command status
// - Reset type 0 hard, 1 soft
// - Application resumes about 25 ms after reset
// - Software timeout 25 ms steps, 8-bit count
// - Timeout value zero disables software watchdog
// - Enable type 0 both, 1 hardware, 2 software
// - Hardware watchdog off only by hard reset
// - Hardware watchdog expiry causes hard reset
// - Software watchdog expiry causes soft reset
// - Refresh returns current count of 25 ms units
// - Reset status: hard, soft, hw on, sw on
// - Reading reset or link status clears its occurrence or error bits
// - Link status: wait, collision, overrun, fault, compare
// - Status bits 7:6 state, bit 5 router
// - Status bit 4 flags link error
// - Status bit 1 flags unexecuted last command
// - Status bit 0 flags watchdog expiry
// - Selected while select line is held
// - Master clocks, data moves both ways
`timescale 1ns/1ps
`include "net_card_supervisor_cfg.svh"

module net_card_supervisor
    import net_card_supervisor_pkg::*;
#(
    parameter int       TICK_CYCLES   = `WDT_UNIT_US * `CLK_MHZ,
    parameter int       RESUME_CYCLES = `RESUME_US * `CLK_MHZ,
    parameter int       HWWDT_TICKS   = `HWWDT_UNITS,
    parameter bit       IS_ROUTER     = 1'b0
) (
    input  wire logic       CLK,
    input  wire logic       RSTN,
    input  wire logic       LINK_SCLK,
    input  wire logic       SS_N,
    input  wire logic       MOSI,
    output logic            MISO,
    input  wire logic       APP_ALIVE,
    input  wire logic [1:0] CARD_BITS,
    output logic            HARD_RST,
    output logic            SOFT_RST
);

    // ======================================================================
    // Link domain: shifts in on rising edges, out on falling edges
    logic       link_rst;
    logic [2:0] bitcnt_r;
    logic [6:0] rxsh_r;
    logic [7:0] rx_byte_r;
    logic       rx_tgl_r;
    logic [7:0] txsh_r;
    logic       loaded_r;
    logic [7:0] tx_word_r;
    logic [7:0] tx_cur;

    // Select high ends the frame asynchronously, as the clock stops with it
    assign link_rst = ~RSTN | SS_N;

    always_ff @(posedge LINK_SCLK or posedge link_rst) begin
        if (link_rst) begin
            bitcnt_r <= 3'h0;
            rxsh_r   <= 7'h00;
        end else begin
            bitcnt_r <= bitcnt_r + 3'h1;
            rxsh_r   <= {rxsh_r[5:0], MOSI};
        end
    end

    // Toggle survives the frame so the core never sees a false event
    always_ff @(posedge LINK_SCLK or negedge RSTN) begin
        if (!RSTN) begin
            rx_byte_r <= 8'h00;
            rx_tgl_r  <= 1'b0;
        end else if (!SS_N && bitcnt_r == 3'h7) begin
            rx_byte_r <= {rxsh_r, MOSI};
            rx_tgl_r  <= ~rx_tgl_r;
        end
    end

    assign tx_cur = loaded_r ? txsh_r : tx_word_r;

    always_ff @(negedge LINK_SCLK or posedge link_rst) begin
        if (link_rst) begin
            txsh_r   <= 8'h00;
            loaded_r <= 1'b0;
        end else begin
            loaded_r <= 1'b1;
            if (loaded_r && bitcnt_r == 3'h0) begin
                txsh_r <= tx_word_r;
            end else begin
                txsh_r <= {tx_cur[6:0], 1'b0};
            end
        end
    end

    // First bit of a frame is the held status byte before any edge
    assign MISO = tx_cur[7];

    // ======================================================================
    // Crossings into the core clock
    logic ss_meta_r, ss_sync_r, ss_prev_r;
    logic tg_meta_r, tg_s1_r, tg_s2_r;
    logic byte_evt, frame_start, frame_end, in_frame;

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            ss_meta_r <= 1'b1;
            ss_sync_r <= 1'b1;
            ss_prev_r <= 1'b1;
            tg_meta_r <= 1'b0;
            tg_s1_r   <= 1'b0;
            tg_s2_r   <= 1'b0;
        end else begin
            ss_meta_r <= SS_N;
            ss_sync_r <= ss_meta_r;
            ss_prev_r <= ss_sync_r;
            tg_meta_r <= rx_tgl_r;
            tg_s1_r   <= tg_meta_r;
            tg_s2_r   <= tg_s1_r;
        end
    end

    // Byte held eight link clocks, long after the toggle has crossed
    assign byte_evt    = tg_s1_r ^ tg_s2_r;
    assign frame_start = ss_prev_r & ~ss_sync_r;
    assign frame_end   = ~ss_prev_r & ss_sync_r;
    assign in_frame    = ~ss_sync_r;

    // ======================================================================
    // Frame capture: command number, first payload byte, length
    logic [4:0] cnt_r;
    logic [7:0] cmd_r, arg_r;
    logic       ovr_r;

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            cnt_r <= 5'h00;
            cmd_r <= 8'h00;
            arg_r <= 8'h00;
            ovr_r <= 1'b0;
        end else if (frame_start) begin
            cnt_r <= 5'h00;
            ovr_r <= 1'b0;
        end else if (byte_evt) begin
            if (cnt_r == 5'h00) cmd_r <= rx_byte_r;
            if (cnt_r == 5'h01) arg_r <= rx_byte_r;
            if (cnt_r <= `MAX_PAYLOAD) begin
                cnt_r <= cnt_r + 5'h01;
            end else begin
                ovr_r <= 1'b1;
            end
        end
    end

    // ======================================================================
    // Command decode at the end of the frame
    rst_state_e state_r;
    logic       hw_en_r, sw_en_r;
    logic [7:0] tmo_r, sw_cnt_r;
    logic       has_arg, idle, sw_exp, hw_exp;
    logic       go_hard, go_soft, set_tmo, en_cmd, hit, rd_rst, rd_comm;
    logic       accepted, bad_code;

    assign has_arg  = cnt_r >= 5'h02;
    assign idle     = state_r == ST_RUN;
    assign go_hard  = frame_end & idle & ~ovr_r & cmd_r == `CMD_RESET & has_arg
                      & arg_r == `RST_HARD;
    assign go_soft  = frame_end & idle & ~ovr_r & cmd_r == `CMD_RESET & has_arg
                      & arg_r == `RST_SOFT;
    assign set_tmo  = frame_end & idle & ~ovr_r & cmd_r == `CMD_SET_TMO & has_arg;
    assign en_cmd   = frame_end & idle & ~ovr_r & cmd_r == `CMD_WDT_EN & has_arg
                      & arg_r <= `WDT_SW_ONLY;
    assign hit      = frame_end & idle & ~ovr_r & cmd_r == `CMD_HIT & sw_en_r & cnt_r != 5'h00;
    assign rd_rst   = frame_end & idle & ~ovr_r & cmd_r == `CMD_RD_RST & cnt_r != 5'h00;
    assign rd_comm  = frame_end & idle & ~ovr_r & cmd_r == `CMD_RD_COMM & cnt_r != 5'h00;
    assign accepted = go_hard | go_soft | set_tmo | en_cmd | hit | rd_rst | rd_comm;
    assign bad_code = frame_end & cnt_r != 5'h00 & ~accepted & ~ovr_r & idle;

    // ======================================================================
    // Reset sequencer: output held for the resume time, then released
    logic [31:0] hold_r;

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            state_r <= ST_RUN;
            hold_r  <= 32'h0;
        end else begin
            unique case (state_r)
                ST_RUN: begin
                    hold_r <= 32'h0;
                    if (go_hard || hw_exp) begin
                        state_r <= ST_HARD;
                    end else if (go_soft || sw_exp) begin
                        state_r <= ST_SOFT;
                    end
                end
                ST_HARD, ST_SOFT: begin
                    if (hold_r == 32'(RESUME_CYCLES - 1)) begin
                        state_r <= ST_RUN;
                    end else begin
                        hold_r <= hold_r + 32'h1;
                    end
                end
            endcase
        end
    end

    assign HARD_RST = state_r == ST_HARD;
    assign SOFT_RST = state_r == ST_SOFT;

    // ======================================================================
    // Watchdog enables and timeout
    logic enter_hard;
    assign enter_hard = idle & (go_hard | hw_exp);

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            hw_en_r <= 1'b0;
            sw_en_r <= 1'b0;
            tmo_r   <= 8'h00;
        end else if (enter_hard) begin
            // A hard reset is the only way the hardware watchdog turns off
            hw_en_r <= 1'b0;
            sw_en_r <= 1'b0;
            tmo_r   <= 8'h00;
        end else begin
            if (set_tmo) tmo_r <= arg_r;
            if (en_cmd && arg_r != `WDT_SW_ONLY) hw_en_r <= 1'b1;
            if (en_cmd && arg_r != `WDT_HW_ONLY) sw_en_r <= 1'b1;
        end
    end

    // ======================================================================
    // 25 ms time base
    logic [31:0] tick_cnt_r;
    logic        tick;

    assign tick = tick_cnt_r == 32'(TICK_CYCLES - 1);

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            tick_cnt_r <= 32'h0;
        end else if (tick) begin
            tick_cnt_r <= 32'h0;
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'h1;
        end
    end

    // ======================================================================
    // Software watchdog: counts down in 25 ms units
    logic sw_live;
    assign sw_live = sw_en_r & tmo_r != `BYTE_ZERO & idle;
    assign sw_exp  = sw_live & tick & sw_cnt_r <= 8'h01;

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            sw_cnt_r <= 8'h00;
        end else if (hit || set_tmo || (en_cmd && arg_r != `WDT_HW_ONLY)) begin
            sw_cnt_r <= set_tmo ? arg_r : tmo_r;
        end else if (sw_exp) begin
            sw_cnt_r <= tmo_r;
        end else if (sw_live && tick) begin
            sw_cnt_r <= sw_cnt_r - 8'h01;
        end
    end

    // ======================================================================
    // Hardware watchdog: refreshed by the card's own heartbeat
    logic [31:0] hw_cnt_r;
    assign hw_exp = hw_en_r & idle & tick & ~APP_ALIVE
                    & hw_cnt_r == 32'(HWWDT_TICKS - 1);

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            hw_cnt_r <= 32'h0;
        end else if (APP_ALIVE || !hw_en_r || !idle || hw_exp) begin
            hw_cnt_r <= 32'h0;
        end else if (tick) begin
            hw_cnt_r <= hw_cnt_r + 32'h1;
        end
    end

    // ======================================================================
    // Reset cause status: occurrence bits clear on read, set wins
    rst_status_s rst_st;
    logic        hard_occ_r, soft_occ_r, wdt_exp_r;

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            hard_occ_r <= 1'b0;
            soft_occ_r <= 1'b0;
            wdt_exp_r  <= 1'b0;
        end else begin
            hard_occ_r <= (idle & (go_hard | hw_exp)) | (hard_occ_r & ~rd_rst);
            soft_occ_r <= (idle & ~enter_hard & (go_soft | sw_exp))
                          | (soft_occ_r & ~rd_rst);
            wdt_exp_r  <= hw_exp | sw_exp | (wdt_exp_r & ~rd_rst);
        end
    end

    // Enable bits show live state; only the occurrence bits are sticky
    assign rst_st = '{hard_occ: hard_occ_r, soft_occ: soft_occ_r,
                      hw_en: hw_en_r, sw_en: sw_en_r, rsvd: 4'h0};

    // ======================================================================
    // Link error status
    comm_status_s comm_r;
    logic         set_coll, set_fault;

    assign set_coll  = frame_end & ~idle;
    assign set_fault = frame_end & cnt_r == 5'h00;

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            comm_r <= '0;
        end else begin
            // Pending byte clears once its frame has been acted on
            comm_r.rx_wait    <= byte_evt | (comm_r.rx_wait & ~frame_end);
            comm_r.collision  <= set_coll | (comm_r.collision & ~rd_comm);
            comm_r.overrun    <= (frame_end & ovr_r) | (comm_r.overrun & ~rd_comm);
            comm_r.mode_fault <= set_fault | (comm_r.mode_fault & ~rd_comm);
            comm_r.compare    <= bad_code | (comm_r.compare & ~rd_comm);
            comm_r.rsvd       <= 3'h0;
        end
    end

    // ======================================================================
    // Transaction status and reply byte
    txn_status_s txn;
    logic        unexec_r;

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            unexec_r <= 1'b0;
        end else if (frame_end) begin
            unexec_r <= ~accepted;
        end
    end

    assign txn.state    = idle ? `STATE_READY : `STATE_BUSY;
    assign txn.router   = IS_ROUTER;
    assign txn.comm_err = comm_r.collision | comm_r.overrun
                          | comm_r.mode_fault | comm_r.compare;
    assign txn.card     = CARD_BITS;
    assign txn.unexec   = unexec_r;
    assign txn.wdt_exp  = wdt_exp_r;

    // Idle: word tracks the status of the last command. After the command
    // byte it holds the reply, sent from the third byte on, because the
    // second byte is already loaded before the command can cross over.
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            tx_word_r <= 8'h00;
        end else if (!in_frame) begin
            tx_word_r <= txn;
        end else if (byte_evt && cnt_r == 5'h00) begin
            unique case (rx_byte_r)
                `CMD_RD_RST:  tx_word_r <= rst_st;
                `CMD_RD_COMM: tx_word_r <= comm_r;
                `CMD_HIT:     tx_word_r <= sw_cnt_r;
                default:      tx_word_r <= `BYTE_ZERO;
            endcase
        end
    end

endmodule // net_card_supervisor

/* net_card_supervisor_properties.sv */
// Checker of the network card supervisor ports
`timescale 1ns/1ps
module net_card_supervisor_chk
    import net_card_supervisor_pkg::*;
#(
    parameter int RESUME_CYCLES = 20,
    parameter bit IS_ROUTER     = 1'b0
) (
    input wire logic       CLK,
    input wire logic       RSTN,
    input wire logic       LINK_SCLK,
    input wire logic       SS_N,
    input wire logic       MISO,
    input wire logic [1:0] CARD_BITS,
    input wire logic       HARD_RST,
    input wire logic       SOFT_RST
);
    int          hard_cnt;
    int          soft_cnt;
    logic [4:0]  bit_cnt;
    txn_status_s first_byte;

    // ========================================
    // Helper counters
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            hard_cnt <= 0;
            soft_cnt <= 0;
        end else begin
            hard_cnt <= HARD_RST ? hard_cnt + 1 : 0;
            soft_cnt <= SOFT_RST ? soft_cnt + 1 : 0;
        end
    end

    // Select high clears the frame position, as in the card itself
    always_ff @(posedge LINK_SCLK or posedge SS_N) begin
        if (SS_N) begin
            bit_cnt <= 5'h00;
        end else begin
            if (bit_cnt < 5'h08) begin
                first_byte <= {first_byte[6:0], MISO};
            end
            if (bit_cnt != 5'h1F) begin
                bit_cnt <= bit_cnt + 5'h01;
            end
        end
    end

    // ========================================
    // Properties
    property p_hard_len;
        @(posedge CLK) disable iff (!RSTN) $fell(HARD_RST) |-> hard_cnt == RESUME_CYCLES;
    endproperty
    a_hard_len: assert property (p_hard_len) else $error("hard reset length wrong");
    property p_soft_len;
        @(posedge CLK) disable iff (!RSTN) $fell(SOFT_RST) |-> soft_cnt == RESUME_CYCLES;
    endproperty
    a_soft_len: assert property (p_soft_len) else $error("soft reset length wrong");
    property p_excl;
        @(posedge CLK) disable iff (!RSTN) $rose(SOFT_RST) |-> !$past(HARD_RST) && !HARD_RST;
    endproperty
    a_excl: assert property (p_excl) else $error("soft reset inside hard reset");
    property p_state;
        @(posedge LINK_SCLK) disable iff (!RSTN) bit_cnt == 5'h08 |-> first_byte.state inside {2'h1, 2'h2};
    endproperty
    a_state: assert property (p_state) else $error("status state code wrong");
    property p_router;
        @(posedge LINK_SCLK) disable iff (!RSTN) bit_cnt == 5'h08 |-> first_byte.router == IS_ROUTER;
    endproperty
    a_router: assert property (p_router) else $error("status router bit wrong");
    property p_card;
        @(posedge LINK_SCLK) disable iff (!RSTN) bit_cnt == 5'h08 |-> first_byte.card == CARD_BITS;
    endproperty
    a_card: assert property (p_card) else $error("status card bits wrong");
    property p_err;
        @(posedge LINK_SCLK) disable iff (!RSTN) bit_cnt == 5'h08 && first_byte.unexec |-> first_byte.comm_err;
    endproperty
    a_err: assert property (p_err) else $error("unexecuted without link error");
    property p_echo;
        @(posedge LINK_SCLK) disable iff (!RSTN)
            bit_cnt inside {[5'h08:5'h0F]} |-> MISO == first_byte[5'h0F - bit_cnt];
    endproperty
    a_echo: assert property (p_echo) else $error("second byte differs from status");
endmodule // net_card_supervisor_chk

bind net_card_supervisor net_card_supervisor_chk #(
    .RESUME_CYCLES(RESUME_CYCLES),
    .IS_ROUTER    (IS_ROUTER)
) u_chk (
    .CLK      (CLK),
    .RSTN     (RSTN),
    .LINK_SCLK(LINK_SCLK),
    .SS_N     (SS_N),
    .MISO     (MISO),
    .CARD_BITS(CARD_BITS),
    .HARD_RST (HARD_RST),
    .SOFT_RST (SOFT_RST)
);

/* net_link_master.sv */
// Behavioural master that frames transfers on the serial link
`timescale 1ns/1ps
module net_link_master (
    output logic      sclk,
    output logic      ss_n,
    output logic      mosi,
    input  wire logic miso
);
    logic [7:0] rx [3];

    initial begin
        sclk = 1'b0; // Clock stands still outside frames
        ss_n = 1'b0;
        mosi = 1'b0;
        // Select rises after the reset edge, so link flops see a clean reset
        #2;
        ss_n = 1'b1;
    end

    // Caller keeps payload to 0..15 bytes except on purpose
    task automatic xfer(input logic [7:0] tx [17], input int n);
        logic [7:0] sh;
        rx = '{default: 8'hXX};
        #13;
        ss_n = 1'b0; // Select held for the whole frame
        #160;
        for (int i = 0; i < n; i++) begin
            for (int b = 7; b >= 0; b--) begin
                mosi = tx[i][b];
                #32;
                sclk = 1'b1; // Both directions are sampled on this rising edge
                sh = {sh[6:0], miso};
                #32;
                sclk = 1'b0;
            end
            if (i < 3) begin
                rx[i] = sh;
            end
        end
        #32;
        ss_n = 1'b1;
        mosi = ~mosi; // No stale level after the frame
        #200;
    endtask
endmodule // net_link_master

/* net_card_supervisor_tb.sv */
// Self-checking bench of the network card supervisor
`timescale 1ns/1ps
`include "net_card_supervisor_cfg.svh"
module net_card_supervisor_tb
    import net_card_supervisor_pkg::*;
;
    localparam int         RES     = 60;
    localparam logic [7:0] ST_OK   = 8'h48;
    localparam logic [7:0] ST_BAD  = 8'h5A;
    localparam logic [7:0] ST_BUSY = 8'h88;
    logic       CLK       = 1'b0;
    logic       RSTN      = 1'b1;
    logic [1:0] CARD_BITS = 2'h2;
    logic       APP_ALIVE = 1'b0;
    logic       alive_en  = 1'b1;
    wire        link_sclk, ss_n, mosi, miso, HARD_RST, SOFT_RST;
    int         bad_count, n_compared, soft_rises, n;
    logic [7:0] tx [17];

    always #20 CLK = ~CLK;
    always @(posedge CLK) APP_ALIVE <= #1 alive_en && !APP_ALIVE;
    always @(posedge SOFT_RST) soft_rises++;

    net_card_supervisor #(.TICK_CYCLES(50), .RESUME_CYCLES(RES), .HWWDT_TICKS(3), .IS_ROUTER(1'b0)) uut (
        .CLK(CLK), .RSTN(RSTN), .LINK_SCLK(link_sclk), .SS_N(ss_n), .MOSI(mosi), .MISO(miso),
        .APP_ALIVE(APP_ALIVE), .CARD_BITS(CARD_BITS), .HARD_RST(HARD_RST), .SOFT_RST(SOFT_RST));
    net_link_master master (.sclk(link_sclk), .ss_n(ss_n), .mosi(mosi), .miso(miso));

    // ========================================
    // Tasks
    task check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic txn(input logic [7:0] cmd, input logic [7:0] arg, input int len);
        tx = '{default: 8'h00};
        tx[0] = cmd;
        tx[1] = arg;
        @(posedge CLK);
        #1;
        master.xfer(tx, len);
    endtask

    task automatic wait_rst(input logic hard, input int lim);
        logic seen;
        seen = 1'b0;
        for (int i = 0; i < lim && !seen; i++) begin
            @(posedge CLK);
            #1;
            seen = hard ? HARD_RST : SOFT_RST;
        end
        check({7'h00, seen}, 8'h01);
    endtask

    // The long settle gap before the next access is scaled down here
    task settle;
        repeat (RES + 4) @(posedge CLK);
        #1;
        check({6'h00, HARD_RST, SOFT_RST}, 8'h00);
    endtask

    task end_of_test;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        #2000000;
        bad_count++;
        end_of_test;
    end

    // ========================================
    // Sequence
    initial begin
        // A real falling edge, so every asynchronous reset fires
        #1;
        RSTN = 1'b0;
        repeat (10) @(posedge CLK);
        #1;
        RSTN = 1'b1;
        repeat (4) @(posedge CLK);
        txn(`CMD_RD_RST, 8'h00, 3);
        check(master.rx[0], ST_OK);
        check(master.rx[2], 8'h00);
        txn(8'h3C, 8'h00, 1);
        txn(`CMD_RD_COMM, 8'h00, 3);
        check(master.rx[0], ST_BAD);
        check(master.rx[2] & 8'h7F, 8'h08);
        txn(`CMD_RD_COMM, 8'h00, 1);
        check(master.rx[0], ST_OK);
        txn(`CMD_RD_COMM, 8'h00, 3);
        check(master.rx[0], ST_OK);
        check(master.rx[2] & 8'h7F, 8'h00);
        txn(`CMD_SET_TMO, 8'h01, 17);
        txn(`CMD_RD_COMM, 8'h00, 3);
        check(master.rx[2] & 8'h7F, 8'h20);
        txn(`CMD_WDT_EN, 8'h07, 2);
        txn(`CMD_RD_COMM, 8'h00, 3);
        check(master.rx[2] & 8'h7F, 8'h08);
        // Software watchdog: program, enable, refresh, then let it expire
        txn(`CMD_SET_TMO, 8'h04, 2);
        txn(`CMD_WDT_EN, `WDT_SW_ONLY, 2);
        txn(`CMD_RD_RST, 8'h00, 3);
        check(master.rx[2], 8'h10);
        txn(`CMD_HIT, 8'h00, 3);
        check({7'h00, (master.rx[2] inside {[8'h01:8'h04]})}, 8'h01);
        // Empty frame right after a refresh must not repeat the refresh
        txn(8'h00, 8'h00, 0);
        txn(`CMD_RD_COMM, 8'h00, 3);
        check(master.rx[0], ST_BAD);
        check(master.rx[2] & 8'h7F, 8'h10);
        wait_rst(1'b0, 400);
        settle;
        txn(`CMD_RD_RST, 8'h00, 3);
        check(master.rx[0], ST_OK | 8'h01);
        check(master.rx[2], 8'h50);
        txn(`CMD_SET_TMO, 8'h00, 2);
        txn(`CMD_RD_RST, 8'h00, 3);
        check(master.rx[2], 8'h10);
        n = soft_rises;
        repeat (400) @(posedge CLK);
        check(8'(soft_rises - n), 8'h00);
        // Hardware watchdog survives a soft reset; a busy card refuses
        txn(`CMD_WDT_EN, `WDT_HW_ONLY, 2);
        txn(`CMD_RESET, `RST_SOFT, 2);
        wait_rst(1'b0, 20);
        txn(`CMD_RD_RST, 8'h00, 1);
        check(master.rx[0], ST_BUSY);
        settle;
        txn(`CMD_RD_COMM, 8'h00, 3);
        check(master.rx[0], ST_BAD);
        check(master.rx[2] & 8'h7F, 8'h40);
        txn(`CMD_RD_RST, 8'h00, 3);
        check(master.rx[2] & 8'hE0, 8'h60);
        alive_en = 1'b0;
        wait_rst(1'b1, 400);
        settle;
        txn(`CMD_RD_RST, 8'h00, 3);
        check(master.rx[0], ST_OK | 8'h01);
        check(master.rx[2], 8'h80);
        alive_en = 1'b1;
        txn(`CMD_WDT_EN, `WDT_BOTH, 2);
        txn(`CMD_RD_RST, 8'h00, 3);
        check(master.rx[2], 8'h30);
        txn(`CMD_RESET, `RST_HARD, 2);
        wait_rst(1'b1, 20);
        settle;
        // Card bits are a live level; change them between frames
        CARD_BITS = 2'h1;
        txn(`CMD_RD_RST, 8'h00, 3);
        check(master.rx[0], 8'h44);
        check(master.rx[2], 8'h80);
        end_of_test;
    end
endmodule // net_card_supervisor_tb
